// file: inc/smd_pkg.sv
// Behaviour
// - bytes go out MSB first; first received bit lands in the MSB
// - bus data shifts in while shifting out; register holds last bus byte
// - lost arbitration reports 0x38 and falls to slave receive, data kept
// - slave compares received address with own-address bits 7..1
// - own-address bit 0 enables general call address 0x00 recognition
// - own address is ignored while acting as master
// - 8-bit state code, low three bits zero while the event flag is set
// - state code is defined only while the event flag is set
// - report 0x08 after START and 0x10 after repeated START
// - address+write sent: 0x18 on ACK, 0x20 on NACK
// - data byte sent: 0x28 on ACK, 0x30 on NACK
// - address+read sent: 0x40 on ACK, 0x48 on NACK
// - byte received: 0x50 when ACK sent, 0x58 when NACK sent
// - idle after a STOP reports 0xF8 (reset loads 0x00) and never sets the event flag
// - illegal START or STOP during a master transfer reports 0x00; a stop request resets
package smd_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [9:0]  STATE_CODE_IDX = 10'h0C1;
  localparam logic [11:0] ADDR_STATE     = {STATE_CODE_IDX, 2'h0};
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_DATA      = 12'h004;
  localparam logic [11:0] ADDR_OWN       = 12'h008;
  localparam logic [11:0] ADDR_RATE      = 12'h00C;

  localparam int CTRL_ENS = 6;
  localparam int CTRL_STA = 5;
  localparam int CTRL_STO = 4;
  localparam int CTRL_SI  = 3;
  localparam int CTRL_AA  = 2;

  localparam logic [7:0] OWN_RST  = 8'h00;
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] TMR_END  = 8'hFF;
  localparam logic [3:0] ACK_BIT  = 4'h8;
  localparam logic [3:0] SLV_DONE = 4'h9;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // state codes
  // ------------------------------------------------------------
  localparam logic [7:0] C_BUS_ERR = 8'h00;
  localparam logic [7:0] C_START   = 8'h08;
  localparam logic [7:0] C_RSTART  = 8'h10;
  localparam logic [7:0] C_AW_ACK  = 8'h18;
  localparam logic [7:0] C_AW_NACK = 8'h20;
  localparam logic [7:0] C_DT_ACK  = 8'h28;
  localparam logic [7:0] C_DT_NACK = 8'h30;
  localparam logic [7:0] C_ARB     = 8'h38;
  localparam logic [7:0] C_AR_ACK  = 8'h40;
  localparam logic [7:0] C_AR_NACK = 8'h48;
  localparam logic [7:0] C_DR_ACK  = 8'h50;
  localparam logic [7:0] C_DR_NACK = 8'h58;
  localparam logic [7:0] C_SW_OWN  = 8'h60;
  localparam logic [7:0] C_SW_GC   = 8'h70;
  localparam logic [7:0] C_SR_OWN  = 8'hA8;
  localparam logic [7:0] C_IDLE    = 8'hF8;

  typedef struct packed {
    logic ens;
    logic start_request;
    logic sto;
    logic si;
    logic aa;
  } smd_ctrl_t;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_START = 7'h02,
    S_LOW   = 7'h04,
    S_HIGH  = 7'h08,
    S_WAIT  = 7'h10,
    S_STOP  = 7'h20,
    S_SLAVE = 7'h40
  } smd_state_t;

endpackage

// file: hw/smd_top.sv
`timescale 1ns/100ps
module smd_top
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n
);

  // ------------------------------------------------------------
  // pin synchronisers and bus condition detect
  // ------------------------------------------------------------
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_p_q, sda_p_q;
  logic       scl_s, sda_s, start_det, stop_det;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_p_q    <= scl_sync_q[1];
      sda_p_q    <= sda_sync_q[1];
    end
  end

  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ------------------------------------------------------------
  // axi4-lite handshake
  // ------------------------------------------------------------
  logic        aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        wr_go, wr_hit;

  smd_pkg::smd_ctrl_t ctl_q, ctl_d;
  smd_pkg::smd_state_t st_q, st_d;
  logic [7:0] data_q, data_d, own_q, own_d, rate_q, rate_d, code_q, code_d;

  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == smd_pkg::ADDR_CTRL) || (a == smd_pkg::ADDR_DATA) ||
              (a == smd_pkg::ADDR_OWN)  || (a == smd_pkg::ADDR_RATE) ||
              (a == smd_pkg::ADDR_STATE);
  endfunction

  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready  = ~w_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign wr_go         = aw_q & w_q;
  assign wr_hit        = wr_go & wstrb0_q;

  always_comb
  begin
    aw_d = aw_q; w_d = w_q; awaddr_d = awaddr_q; wdata_d = wdata_q;
    wstrb0_d = wstrb0_q; bvalid_d = bvalid_q; bresp_d = bresp_q;
    rvalid_d = rvalid_q; rdata_d = rdata_q; rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_d = 1'b1; awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_d = 1'b1; wdata_d = s_axi_wdata; wstrb0_d = s_axi_wstrb[0];
    end
    if (wr_go)
    begin
      aw_d = 1'b0; w_d = 1'b0; bvalid_d = 1'b1;
      bresp_d = reg_hit(awaddr_q) ? smd_pkg::RESP_OKAY : smd_pkg::RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = reg_hit(s_axi_araddr) ? smd_pkg::RESP_OKAY : smd_pkg::RESP_SLVERR;
      rdata_d  = 32'h0000_0000;
      unique case (s_axi_araddr)
        smd_pkg::ADDR_CTRL:  rdata_d[7:0] = {1'b0, ctl_q.ens, ctl_q.start_request, ctl_q.sto,
                                             ctl_q.si, ctl_q.aa, 2'h0};
        smd_pkg::ADDR_DATA:  rdata_d[7:0] = data_q;
        smd_pkg::ADDR_OWN:   rdata_d[7:0] = own_q;
        smd_pkg::ADDR_RATE:  rdata_d[7:0] = rate_q;
        smd_pkg::ADDR_STATE: rdata_d[7:0] = code_q;
        default:             rdata_d[7:0] = 8'h00;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0; w_q <= 1'b0; awaddr_q <= 12'h000; wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0; bvalid_q <= 1'b0; bresp_q <= 2'h0;
      rvalid_q <= 1'b0; rdata_q <= 32'h0000_0000; rresp_q <= 2'h0;
    end
    else
    begin
      aw_q <= aw_d; w_q <= w_d; awaddr_q <= awaddr_d; wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d; bvalid_q <= bvalid_d; bresp_q <= bresp_d;
      rvalid_q <= rvalid_d; rdata_q <= rdata_d; rresp_q <= rresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ------------------------------------------------------------
  // registers and bus engine
  // ------------------------------------------------------------
  logic [7:0] tmr_q, tmr_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] ph_q, ph_d;
  logic       scl_drv_q, scl_drv_d, sda_drv_q, sda_drv_d;
  logic       addr_ph_q, addr_ph_d, rd_q, rd_d, rep_q, rep_d, busy_q, busy_d;
  logic       tdone, tx, lost, match;

  assign tdone = (tmr_q == smd_pkg::TMR_END);
  assign tx    = addr_ph_q | ~rd_q;
  assign lost  = tx & data_q[7] & ~sda_s;
  // own address is only looked at from the slave path, never as master
  assign match = ((data_q[7:1] == own_q[7:1]) |
                  ((data_q[7:1] == 7'h00) & own_q[0] & ~data_q[0]));

  always_comb
  begin
    ctl_d = ctl_q; st_d = st_q; data_d = data_q; own_d = own_q; rate_d = rate_q;
    code_d = code_q; bit_d = bit_q; ph_d = ph_q; scl_drv_d = scl_drv_q;
    sda_drv_d = sda_drv_q; addr_ph_d = addr_ph_q; rd_d = rd_q; rep_d = rep_q;
    busy_d = (busy_q | start_det) & ~stop_det;
    tmr_d = tdone ? tmr_q : tmr_q + 8'h01;
    // state code writes are dropped: its value belongs to the engine
    if (wr_hit)
    begin
      unique case (awaddr_q)
        smd_pkg::ADDR_CTRL:
        begin
          ctl_d.ens = wdata_q[smd_pkg::CTRL_ENS];
          ctl_d.start_request = wdata_q[smd_pkg::CTRL_STA];
          ctl_d.sto = wdata_q[smd_pkg::CTRL_STO];
          ctl_d.aa  = wdata_q[smd_pkg::CTRL_AA];
          if (!wdata_q[smd_pkg::CTRL_SI])
            ctl_d.si = 1'b0;
        end
        smd_pkg::ADDR_DATA: data_d = wdata_q[7:0];
        smd_pkg::ADDR_OWN:  own_d  = wdata_q[7:0];
        smd_pkg::ADDR_RATE: rate_d = wdata_q[7:0];
        default: ;
      endcase
    end
    // hardware events below come after the software clear, so a set wins
    unique case (st_q)
      smd_pkg::S_IDLE:
      begin
        scl_drv_d = 1'b0; sda_drv_d = 1'b0; rep_d = 1'b0;
        if (ctl_q.sto)
          ctl_d.sto = 1'b0;
        else if (ctl_q.ens && ctl_q.start_request && !busy_q && scl_s && sda_s)
        begin
          st_d = smd_pkg::S_START; ph_d = 2'h2; sda_drv_d = 1'b1; tmr_d = rate_q;
        end
        else if (ctl_q.ens && start_det)
        begin
          st_d = smd_pkg::S_SLAVE; bit_d = 4'h0;
        end
      end
      smd_pkg::S_START:
      begin
        if (ph_q == 2'h1 && !scl_s)
          tmr_d = rate_q;                        // wait out clock stretching
        else if (tdone)
        begin
          tmr_d = rate_q;
          ph_d  = ph_q + 2'h1;
          if (ph_q == 2'h0)
            scl_drv_d = 1'b0;
          else if (ph_q == 2'h1)
            sda_drv_d = 1'b1;
          else
          begin
            scl_drv_d = 1'b1; st_d = smd_pkg::S_WAIT; ctl_d.si = 1'b1;
            code_d = rep_q ? smd_pkg::C_RSTART : smd_pkg::C_START;
            rep_d = 1'b1; addr_ph_d = 1'b1;
          end
        end
      end
      smd_pkg::S_WAIT:
      begin
        if (!ctl_q.si)
        begin
          tmr_d = rate_q; ph_d = 2'h0;
          if (ctl_q.sto)
          begin
            st_d = smd_pkg::S_STOP; sda_drv_d = 1'b1;
          end
          else if (ctl_q.start_request)
          begin
            st_d = smd_pkg::S_START; sda_drv_d = 1'b0;
          end
          else
          begin
            st_d = smd_pkg::S_LOW; bit_d = 4'h0;
            if (addr_ph_q)
              rd_d = data_q[0];
          end
        end
      end
      smd_pkg::S_LOW:
      begin
        if (bit_q == smd_pkg::ACK_BIT)
          sda_drv_d = ~tx & ctl_q.aa;
        else
          sda_drv_d = tx & ~data_q[7];
        if (tdone)
        begin
          scl_drv_d = 1'b0; st_d = smd_pkg::S_HIGH; tmr_d = rate_q;
        end
      end
      smd_pkg::S_HIGH:
      begin
        if (!scl_s)
          tmr_d = rate_q;
        else if (start_det || stop_det)
        begin
          st_d = smd_pkg::S_IDLE; code_d = smd_pkg::C_BUS_ERR;
          ctl_d.si = 1'b1; scl_drv_d = 1'b0; sda_drv_d = 1'b0;
        end
        else if (tdone)
        begin
          tmr_d = rate_q;
          if (bit_q != smd_pkg::ACK_BIT)
          begin
            data_d = {data_q[6:0], sda_s};
            bit_d  = bit_q + 4'h1;
            if (lost)
            begin
              st_d = smd_pkg::S_SLAVE; code_d = smd_pkg::C_ARB;
              ctl_d.si = 1'b1; scl_drv_d = 1'b0; sda_drv_d = 1'b0;
            end
            else
            begin
              scl_drv_d = 1'b1; st_d = smd_pkg::S_LOW;
            end
          end
          else
          begin
            scl_drv_d = 1'b1; st_d = smd_pkg::S_WAIT; ctl_d.si = 1'b1; addr_ph_d = 1'b0;
            if (addr_ph_q && rd_q)
              code_d = sda_s ? smd_pkg::C_AR_NACK : smd_pkg::C_AR_ACK;
            else if (addr_ph_q)
              code_d = sda_s ? smd_pkg::C_AW_NACK : smd_pkg::C_AW_ACK;
            else if (rd_q)
              code_d = sda_drv_q ? smd_pkg::C_DR_ACK : smd_pkg::C_DR_NACK;
            else
              code_d = sda_s ? smd_pkg::C_DT_NACK : smd_pkg::C_DT_ACK;
          end
        end
      end
      smd_pkg::S_STOP:
      begin
        if (ph_q == 2'h1 && !scl_s)
          tmr_d = rate_q;
        else if (tdone)
        begin
          tmr_d = rate_q;
          ph_d  = ph_q + 2'h1;
          if (ph_q == 2'h0)
            scl_drv_d = 1'b0;
          else if (ph_q == 2'h1)
            sda_drv_d = 1'b0;
          else
          begin
            st_d = smd_pkg::S_IDLE; ctl_d.sto = 1'b0; code_d = smd_pkg::C_IDLE;
          end
        end
      end
      smd_pkg::S_SLAVE:
      begin
        // follows the remote clock; codes beyond address match are not produced
        if (start_det || stop_det)
        begin
          st_d = smd_pkg::S_IDLE; sda_drv_d = 1'b0;
        end
        else if (scl_s && !scl_p_q && bit_q < smd_pkg::ACK_BIT)
        begin
          data_d = {data_q[6:0], sda_s};
          bit_d  = bit_q + 4'h1;
        end
        else if (!scl_s && scl_p_q && bit_q == smd_pkg::ACK_BIT)
        begin
          sda_drv_d = match & ctl_q.aa & (~data_q[0] | (data_q[7:1] != 7'h00));
          bit_d = smd_pkg::SLV_DONE;
        end
        else if (!scl_s && scl_p_q && bit_q == smd_pkg::SLV_DONE)
        begin
          st_d = smd_pkg::S_IDLE;
          if (sda_drv_q)
          begin
            ctl_d.si = 1'b1;
            code_d = data_q[0] ? smd_pkg::C_SR_OWN :
                     ((data_q[7:1] == 7'h00) ? smd_pkg::C_SW_GC : smd_pkg::C_SW_OWN);
          end
          sda_drv_d = 1'b0;
        end
      end
    endcase
    if (!ctl_q.ens)
    begin
      st_d = smd_pkg::S_IDLE; scl_drv_d = 1'b0; sda_drv_d = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_q <= '0; st_q <= smd_pkg::S_IDLE; data_q <= 8'h00;
      own_q <= smd_pkg::OWN_RST; rate_q <= smd_pkg::RATE_RST;
      code_q <= smd_pkg::CODE_RST; tmr_q <= 8'h00; bit_q <= 4'h0; ph_q <= 2'h0;
      scl_drv_q <= 1'b0; sda_drv_q <= 1'b0; addr_ph_q <= 1'b0; rd_q <= 1'b0;
      rep_q <= 1'b0; busy_q <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d; st_q <= st_d; data_q <= data_d; own_q <= own_d; rate_q <= rate_d;
      code_q <= code_d; tmr_q <= tmr_d; bit_q <= bit_d; ph_q <= ph_d;
      scl_drv_q <= scl_drv_d; sda_drv_q <= sda_drv_d; addr_ph_q <= addr_ph_d;
      rd_q <= rd_d; rep_q <= rep_d; busy_q <= busy_d;
    end
  end

  // open drain: only ever pull low
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = ~scl_drv_q;
  assign sda_oe_n = ~sda_drv_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_code_aligned;
    @(posedge aclk) disable iff (!aresetn) ctl_q.si |-> code_q[2:0] == 3'h0;
  endproperty
  a_code_aligned: assert property (p_code_aligned) else $error("code not aligned");

  property p_idle_no_si;
    @(posedge aclk) disable iff (!aresetn) $rose(ctl_q.si) |-> code_q != smd_pkg::C_IDLE;
  endproperty
  a_idle_no_si: assert property (p_idle_no_si) else $error("idle set flag");

  property p_start_code;
    @(posedge aclk) disable iff (!aresetn)
      $rose(ctl_q.si) && $past(st_q) == smd_pkg::S_START |->
        code_q == ($past(rep_q) ? smd_pkg::C_RSTART : smd_pkg::C_START);
  endproperty
  a_start_code: assert property (p_start_code) else $error("bad start code");

  property p_aw_code;
    @(posedge aclk) disable iff (!aresetn)
      $rose(ctl_q.si) && $past(st_q) == smd_pkg::S_HIGH && $past(addr_ph_q) && !$past(rd_q)
        |-> code_q == ($past(sda_s) ? smd_pkg::C_AW_NACK : smd_pkg::C_AW_ACK);
  endproperty
  a_aw_code: assert property (p_aw_code) else $error("bad write address code");

  property p_dt_code;
    @(posedge aclk) disable iff (!aresetn)
      $rose(ctl_q.si) && $past(st_q) == smd_pkg::S_HIGH && !$past(addr_ph_q) && !$past(rd_q)
        && $past(bit_q) == smd_pkg::ACK_BIT
        |-> code_q == ($past(sda_s) ? smd_pkg::C_DT_NACK : smd_pkg::C_DT_ACK);
  endproperty
  a_dt_code: assert property (p_dt_code) else $error("bad data sent code");

  property p_ar_code;
    @(posedge aclk) disable iff (!aresetn)
      $rose(ctl_q.si) && $past(st_q) == smd_pkg::S_HIGH && $past(addr_ph_q) && $past(rd_q)
        |-> code_q == ($past(sda_s) ? smd_pkg::C_AR_NACK : smd_pkg::C_AR_ACK);
  endproperty
  a_ar_code: assert property (p_ar_code) else $error("bad read address code");

  property p_dr_code;
    @(posedge aclk) disable iff (!aresetn)
      $rose(ctl_q.si) && $past(st_q) == smd_pkg::S_HIGH && !$past(addr_ph_q) && $past(rd_q)
        && $past(bit_q) == smd_pkg::ACK_BIT
        |-> code_q == ($past(sda_drv_q) ? smd_pkg::C_DR_ACK : smd_pkg::C_DR_NACK);
  endproperty
  a_dr_code: assert property (p_dr_code) else $error("bad data received code");

  property p_arb_lost;
    @(posedge aclk) disable iff (!aresetn)
      st_q == smd_pkg::S_HIGH && scl_s && tdone && bit_q != smd_pkg::ACK_BIT && lost
        && !start_det && !stop_det && ctl_q.ens
        |=> code_q == smd_pkg::C_ARB && ctl_q.si && st_q == smd_pkg::S_SLAVE && sda_oe_n;
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("arbitration loss missed");

  property p_msb_first;
    @(posedge aclk) disable iff (!aresetn)
      st_q == smd_pkg::S_HIGH && tx && bit_q != smd_pkg::ACK_BIT |-> sda_oe_n == data_q[7];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit order wrong");

  property p_shift_in;
    @(posedge aclk) disable iff (!aresetn)
      st_q == smd_pkg::S_HIGH && scl_s && tdone && bit_q != smd_pkg::ACK_BIT
        && !start_det && !stop_det && !wr_hit
        |=> data_q == {$past(data_q[6:0]), $past(sda_s)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bus bit not shifted in");

endmodule

// file: tb/smd_slave_model.sv
`timescale 1ns/100ps
// --------------------------------------------------
// bus-side target: acks its address, answers reads
// --------------------------------------------------
module smd_slave_model
#(
  parameter logic [6:0] ADDR  = 7'h2A,
  parameter logic [7:0] RDATA = 8'hA5
)
(
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe_n
);
  logic [7:0] sr = 8'h00;
  logic       rd = 1'b0;
  logic       first = 1'b0;
  logic       hit = 1'b0;
  logic       nack = 1'b1;
  int         n = 0;
  initial sda_oe_n = 1'b1;
  // start or repeated start
  always @(negedge sda)
    if (scl)
    begin
      n = 0;
      first = 1'b1;
      rd = 1'b0;
    end
  // stop frees the line
  always @(posedge sda)
    if (scl)
      sda_oe_n = 1'b1;
  always @(posedge scl)
  begin
    if (n < 8)
      sr = {sr[6:0], sda};
    else
      nack = sda;
    n++;
  end
  // change sda only while scl is low, so no false start or stop
  always @(negedge scl)
  begin
    if (n == 8 && first)
    begin
      hit = (sr[7:1] == ADDR);
      rd = sr[0];
      first = 1'b0;
      sda_oe_n = !hit;
    end
    else if (n == 8)
      sda_oe_n = rd || !hit;
    else if (n == 9)
    begin
      n = 0;
      sda_oe_n = (rd && hit && !nack) ? RDATA[7] : 1'b1;
    end
    else if (rd && hit && n > 0)
      sda_oe_n = RDATA[7 - n];
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb;
  typedef struct packed {
    logic [8:0] ld;
    logic [7:0] ctrl;
    logic [7:0] code;
    logic [8:0] dat;
  } smd_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, scl_oe_n, sda_oe_n, slv_oe_n;
  logic [1:0]  bresp, rresp, rsp;
  wire         scl_w = scl_oe_n;
  wire         sda_w = sda_oe_n & slv_oe_n;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  // ld/dat bit 8: load or check the serial byte
  smd_row_t rows [11] = '{
    '{9'h000, 8'h60, 8'h08, 9'h000}, '{9'h154, 8'h40, 8'h18, 9'h154},
    '{9'h13C, 8'h40, 8'h28, 9'h13C}, '{9'h000, 8'h60, 8'h10, 9'h000},
    '{9'h155, 8'h44, 8'h40, 9'h155}, '{9'h000, 8'h44, 8'h50, 9'h1A5},
    '{9'h000, 8'h40, 8'h58, 9'h1A5}, '{9'h000, 8'h70, 8'h08, 9'h000},
    '{9'h124, 8'h40, 8'h20, 9'h000}, '{9'h000, 8'h60, 8'h10, 9'h000},
    '{9'h125, 8'h40, 8'h48, 9'h000}};
  smd_top u_smd_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_in(scl_w), .scl_out(), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(), .sda_oe_n(sda_oe_n));
  smd_slave_model u_smd_slave_model (.scl(scl_w), .sda(sda_w), .sda_oe_n(slv_oe_n));
  // --------------------------------------------------
  // bus tasks
  // --------------------------------------------------
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ok_a, ok_w;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ok_a = awvalid & awready;
      ok_w = wvalid & wready;
      @(posedge aclk);
      if (ok_a) awvalid <= 1'b0;
      if (ok_w) wvalid <= 1'b0;
    end while ((awvalid & !ok_a) | (wvalid & !ok_w));
    do @(negedge aclk); while (!bvalid);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // poll the control word until bit b reads e; the sweep bounds the wait
  task automatic poll(input int b, input logic e);
    v = {32{!e}};
    for (int k = 0; k < 500 && v[b] !== e; k++) axi_rd(smd_pkg::ADDR_CTRL, v, rsp);
    `CHK(v[b], e)
  endtask
  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
    forever #12.5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      end_sim();
    end
  end
  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(smd_pkg::ADDR_STATE, v, rsp);
    `CHK(v, 32'h0)
    axi_rd(smd_pkg::ADDR_OWN, v, rsp);
    `CHK(v, 32'h0)
    axi_rd(12'h100, v, rsp);
    `CHK({v, rsp}, {32'h0, smd_pkg::RESP_SLVERR})
    axi_wr(12'h100, 8'h5A, rsp);
    `CHK(rsp, smd_pkg::RESP_SLVERR)
    // own address equals the target's: master mode must not answer itself
    axi_wr(smd_pkg::ADDR_OWN, 8'h55, rsp);
    axi_rd(smd_pkg::ADDR_OWN, v, rsp);
    `CHK(v[7:0], 8'h55)
    axi_wr(smd_pkg::ADDR_RATE, 8'hF0, rsp);
    for (int i = 0; i < 11; i++)
    begin
      if (rows[i].ld[8]) axi_wr(smd_pkg::ADDR_DATA, rows[i].ld[7:0], rsp);
      axi_wr(smd_pkg::ADDR_CTRL, rows[i].ctrl, rsp);
      poll(3, 1'b1);
      axi_rd(smd_pkg::ADDR_STATE, v, rsp);
      `CHK(v[7:0], rows[i].code)
      axi_rd(smd_pkg::ADDR_DATA, v, rsp);
      if (rows[i].dat[8]) `CHK(v[7:0], rows[i].dat[7:0])
    end
    axi_wr(smd_pkg::ADDR_CTRL, 8'h50, rsp);
    poll(4, 1'b0);
    `CHK(v[3], 1'b0)
    axi_rd(smd_pkg::ADDR_STATE, v, rsp);
    `CHK(v[7:0], 8'hF8)
    // mid-run reset: registers and line drivers return to their reset state
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(smd_pkg::ADDR_OWN, v, rsp);
    `CHK(v, 32'h0)
    axi_rd(smd_pkg::ADDR_CTRL, v, rsp);
    `CHK(v, 32'h0)
    `CHK({scl_oe_n, sda_oe_n}, 2'h3)
    end_sim();
  end
endmodule
